// >>> rtl/itw_watchdog.sv
// Purpose: internal timer watchdog with wishbone classic register slave
// Assumes: rc and subclock arrive as asynchronous pins, sampled on mclk
// Notes: all other inputs are synchronous to mclk
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "itw_map.svh"

module itw_watchdog #(
  parameter int CNT_W = 17,
  parameter int ADR_W = 18
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rcwdt_rst,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rc_clk_pin,
  input wire logic sub_clk_pin,
  input wire logic crystal_osc_enable,
  input wire logic rc_osc_start,
  input wire logic standby,
  input wire logic hold_mode,
  output logic wd_reset_o,
  output logic rc_osc_req_o,
  output logic irq_o
);

  if (CNT_W != 17) begin : g_bad_cnt_w
    $error("counter width must be 17");
  end
  if (ADR_W < `ITW_IDX_W + 2) begin : g_bad_adr_w
    $error("address too narrow for the register map");
  end

  itw_pkg::itw_ctrl_t ctrl_r;
  itw_pkg::itw_ctrl_t ctrl_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [`ITW_EV_W-1:0] stat_r;
  logic [`ITW_EV_W-1:0] mask_r;
  logic rc_rise;
  logic sub_rise;
  logic standby_q_r;
  logic hold_q_r;

  // clock pins: two flops, then an edge stage
  itw_pin_edge u_itw_pin_edge_rc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(rc_clk_pin),
    .rise(rc_rise)
  );

  itw_pin_edge u_itw_pin_edge_sub (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(sub_clk_pin),
    .rise(sub_rise)
  );

  // standby and hold entry edges
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      standby_q_r <= 1'b0;
      hold_q_r <= 1'b0;
    end else begin
      standby_q_r <= standby;
      hold_q_r <= hold_mode;
    end
  end

  wire wd_tick = ctrl_r.cksel ? sub_rise : rc_rise;
  wire stby_rise = standby & ~standby_q_r;
  wire hold_rise = hold_mode & ~hold_q_r;
  wire freeze = standby & (ctrl_r.sb_act == itw_pkg::ITW_SB_FREEZE);
  wire tick_en = ctrl_r.run & wd_tick & ~freeze;

  // terminal count minus one, per overflow select
  wire [CNT_W:0] tc = `ITW_TC_BASE << ctrl_r.ovsel;
  wire [CNT_W-1:0] tc_m1 = CNT_W'(tc - (CNT_W+1)'(1));
  wire ovf_hit = tick_en & (cnt_r == tc_m1);
  wire sub_fail = ctrl_r.run & ctrl_r.cksel & (~crystal_osc_enable | hold_rise);
  wire wd_fault = ovf_hit | sub_fail;
  wire stby_stop = ctrl_r.run & stby_rise & (ctrl_r.sb_act == itw_pkg::ITW_SB_STOP);

  // wishbone decode
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire [`ITW_IDX_W-1:0] idx = wb_adr_i[`ITW_IDX_W+1:2];
  wire hit_ctrl = idx == `ITW_IDX_CTRL;
  wire hit_stat = idx == `ITW_IDX_STAT;
  wire hit_mask = idx == `ITW_IDX_MASK;
  wire wr_fire = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr_fire & hit_ctrl;
  wire clr_cmd = wr_ctrl & ctrl_r.run & (wb_dat_i[7:0] == `ITW_CLR_CMD);
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_r} :
                       hit_stat ? {29'h0, stat_r} :
                       hit_mask ? {29'h0, mask_r} : 32'h0;

  wire [`ITW_EV_W-1:0] ev_set = {clr_cmd, sub_fail, ovf_hit};
  wire [`ITW_EV_W-1:0] ev_clr = (wr_fire & hit_stat) ? wb_dat_i[`ITW_EV_W-1:0] : `ITW_EV_RST;
  wire [`ITW_EV_W-1:0] stat_nxt = ev_set | (stat_r & ~ev_clr);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wd_fault) begin
      ctrl_nxt.flag = 1'b1;
      ctrl_nxt.run = 1'b0;
    end else if (stby_stop) begin
      ctrl_nxt.run = 1'b0;
    end else if (wr_ctrl && !ctrl_r.run) begin
      ctrl_nxt = itw_pkg::itw_ctrl_t'(wb_dat_i[7:0]);
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (!ctrl_r.run || wd_fault || clr_cmd) begin
      cnt_nxt = '0;
    end else if (tick_en) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || rcwdt_rst) begin
      ctrl_r <= itw_pkg::itw_ctrl_t'(`ITW_CTRL_RST);
      cnt_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_r <= `ITW_EV_RST;
      mask_r <= `ITW_EV_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      wd_reset_o <= 1'b0;
      rc_osc_req_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_fire && hit_mask) begin
        mask_r <= wb_dat_i[`ITW_EV_W-1:0];
      end
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
      wd_reset_o <= wd_fault;
      rc_osc_req_o <= (~ctrl_nxt.cksel & ctrl_nxt.run) | rc_osc_start;
      irq_o <= |(stat_nxt & mask_r);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || rcwdt_rst);

  property p_run_zero;
    !ctrl_r.run |=> cnt_r == '0;
  endproperty
  a_run_zero: assert property (p_run_zero) else $error("counter not held while stopped");

  property p_count_up;
    tick_en && !wd_fault && !clr_cmd |=> cnt_r == $past(cnt_r) + CNT_W'(1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter failed to advance");

  property p_ovf_reset;
    ovf_hit |=> wd_reset_o && !ctrl_r.run && ctrl_r.flag && cnt_r == '0;
  endproperty
  a_ovf_reset: assert property (p_ovf_reset) else $error("overflow did not reset");

  property p_ovf_count;
    wd_reset_o && !$past(sub_fail) |-> $past(cnt_r) == $past(tc_m1) && $past(ctrl_r.run);
  endproperty
  a_ovf_count: assert property (p_ovf_count) else $error("reset at wrong count");

  property p_keep_fields;
    wd_fault |=> ctrl_r.cksel == $past(ctrl_r.cksel) && ctrl_r.sb_act == $past(ctrl_r.sb_act)
      && ctrl_r.ovsel == $past(ctrl_r.ovsel);
  endproperty
  a_keep_fields: assert property (p_keep_fields) else $error("fields lost on reset");

  property p_ignore_write;
    wr_ctrl && ctrl_r.run && !wd_fault && !stby_stop |=> ctrl_r == $past(ctrl_r);
  endproperty
  a_ignore_write: assert property (p_ignore_write) else $error("write taken while running");

  property p_clear;
    clr_cmd && !wd_fault |=> cnt_r == '0 ##1 cnt_r <= CNT_W'(1);
  endproperty
  a_clear: assert property (p_clear) else $error("clear command failed");

  property p_freeze;
    ctrl_r.run && freeze && !clr_cmd && !wd_fault |=> cnt_r == $past(cnt_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while frozen");

  property p_stby_stop;
    stby_stop && !wd_fault |=> !ctrl_r.run && !wd_reset_o;
  endproperty
  a_stby_stop: assert property (p_stby_stop) else $error("standby stop failed");

  property p_sub_fail;
    sub_fail |=> wd_reset_o && ctrl_r.flag && !ctrl_r.run;
  endproperty
  a_sub_fail: assert property (p_sub_fail) else $error("subclock loss not caught");

  property p_rc_req;
    !ctrl_r.cksel && ctrl_r.run && !wd_fault && !stby_stop |=> rc_osc_req_o;
  endproperty
  a_rc_req: assert property (p_rc_req) else $error("rc oscillator not requested");

  property p_ack;
    bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer malformed");

  property p_src_rc;
    ctrl_r.run && !ctrl_r.cksel && !rc_rise && !clr_cmd |=> cnt_r == $past(cnt_r);
  endproperty
  a_src_rc: assert property (p_src_rc) else $error("rc count without edge");

  property p_src_sub;
    ctrl_r.run && ctrl_r.cksel && !sub_rise && !clr_cmd && !wd_fault |=> cnt_r == $past(cnt_r);
  endproperty
  a_src_sub: assert property (p_src_sub) else $error("subclock count without edge");

  property p_cnt_limit;
    ctrl_r.run |-> cnt_r <= tc_m1;
  endproperty
  a_cnt_limit: assert property (p_cnt_limit) else $error("counter past terminal count");

  property p_stby_run;
    ctrl_r.run && standby && ctrl_r.sb_act != itw_pkg::ITW_SB_FREEZE && wd_tick && !wd_fault
      && !clr_cmd |=> cnt_r == $past(cnt_r) + CNT_W'(1);
  endproperty
  a_stby_run: assert property (p_stby_run) else $error("counting stopped in standby");

  property p_run_load;
    wr_ctrl && !ctrl_r.run |=> ctrl_r == itw_pkg::itw_ctrl_t'($past(wb_dat_i[7:0]));
  endproperty
  a_run_load: assert property (p_run_load) else $error("write refused while stopped");

  property p_ovf_stat;
    ovf_hit |=> stat_r[`ITW_EV_OVF];
  endproperty
  a_ovf_stat: assert property (p_ovf_stat) else $error("overflow event lost");

  property p_sub_stat;
    sub_fail |=> stat_r[`ITW_EV_SUB];
  endproperty
  a_sub_stat: assert property (p_sub_stat) else $error("subclock event lost");

  property p_clr_stat;
    clr_cmd |=> stat_r[`ITW_EV_CLR];
  endproperty
  a_clr_stat: assert property (p_clr_stat) else $error("clear event lost");

  property p_stat_keep;
    stat_r[`ITW_EV_OVF] && !ev_clr[`ITW_EV_OVF] |=> stat_r[`ITW_EV_OVF];
  endproperty
  a_stat_keep: assert property (p_stat_keep) else $error("status bit dropped");

  property p_pulse;
    wd_reset_o |=> !wd_reset_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("watchdog reset too long");

  property p_idle_quiet;
    !ctrl_r.run |=> !wd_reset_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("reset while stopped");

  property p_rc_idle;
    ctrl_r.cksel && !wr_ctrl && !rc_osc_start |=> !rc_osc_req_o;
  endproperty
  a_rc_idle: assert property (p_rc_idle) else $error("rc oscillator requested idly");

  property p_irq;
    $stable(mask_r) |-> irq_o == |(stat_r & mask_r);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_mask_keep;
    !(wr_fire && hit_mask) |=> $stable(mask_r);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask changed without write");

  property p_ack_req;
    !bus_req |=> !wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("answer without request");

  c_ovf: cover property (ovf_hit);
  c_clear: cover property (clr_cmd ##[1:50] tick_en);
  c_stby: cover property (stby_stop);
  c_freeze: cover property (ctrl_r.run && freeze && wd_tick);
  c_hold: cover property (hold_rise && ctrl_r.run && ctrl_r.cksel);

endmodule

module itw_pin_edge #(
  parameter int STAGES = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin,
  output logic rise
);

  logic [STAGES:0] sync_r;

  if (STAGES < 2) begin : g_bad_stages
    $error("pin synchroniser needs two stages or more");
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[STAGES-1:0], pin};
    end
  end

  assign rise = sync_r[STAGES-1] & ~sync_r[STAGES];

endmodule
`default_nettype wire

// >>> rtl/itw_map.svh
// Purpose: register map and field positions of the internal timer watchdog
// Assumes: register index times four is the byte address
// Notes: definitions only
`ifndef ITW_MAP_SVH
`define ITW_MAP_SVH
`define ITW_IDX_W 16
`define ITW_IDX_CTRL 16'hfe79
`define ITW_IDX_STAT 16'hfe7a
`define ITW_IDX_MASK 16'hfe7b
`define ITW_CTRL_RST 8'h00
`define ITW_CLR_CMD 8'h55
`define ITW_EV_W 3
`define ITW_EV_OVF 0
`define ITW_EV_SUB 1
`define ITW_EV_CLR 2
`define ITW_EV_RST 3'h0
`define ITW_TC_BASE 18'h00400
`endif

// >>> rtl/itw_pkg.sv
// Purpose: types of the internal timer watchdog
// Assumes: control layout flag, clock select, run, standby action, overflow select
// Notes: field order matches the control register bits 7 down to 0
package itw_pkg;
  typedef enum logic [1:0] {
    ITW_SB_RUN = 2'h0,
    ITW_SB_STOP = 2'h1,
    ITW_SB_FREEZE = 2'h2,
    ITW_SB_RUN2 = 2'h3
  } itw_sb_t;

  typedef struct packed {
    logic flag;
    logic cksel;
    logic run;
    itw_sb_t sb_act;
    logic [2:0] ovsel;
  } itw_ctrl_t;
endpackage

// >>> sim/itw_watchdog_tb.sv
// Purpose: self-checking bench of the internal timer watchdog
// Assumes: wishbone classic master, rc pin toggled slowly, sub pin held low
// Notes: wd_reset_o pulses are counted in rsts
`timescale 1ns/1ps
`default_nettype none
`include "itw_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module itw_watchdog_tb;
  logic mclk = 0;
  logic sys_rst = 1;
  logic rcwdt_rst = 0;
  logic wb_we_i = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic [17:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o, rc = 0, sub = 0, xen = 1, rcs = 0, stby = 0, hold = 0, wrst, rreq, irq;
  int errors = 0;
  int compares = 0;
  int rsts = 0;
  itw_watchdog u_itw_watchdog (.mclk(mclk), .sys_rst(sys_rst), .rcwdt_rst(rcwdt_rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'h1), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rc_clk_pin(rc), .sub_clk_pin(sub), .crystal_osc_enable(xen), .rc_osc_start(rcs),
    .standby(stby), .hold_mode(hold), .wd_reset_o(wrst), .rc_osc_req_o(rreq), .irq_o(irq));
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (wrst === 1'b1) rsts <= rsts + 1;
  task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge mclk);
      rc <= 1;
      repeat (3) @(posedge mclk);
      rc <= 0;
    end
    repeat (6) @(posedge mclk);
  endtask
  task automatic t_overflow;
    wb(1, `ITW_IDX_CTRL, 8'h38);
    repeat (2) @(posedge mclk);
    `CHK("osc_req", 1'b1, rreq)
    stby <= 1;
    ticks(1023);
    stby <= 0;
    `CHK("early_rst", 0, rsts)
    ticks(1);
    `CHK("ovf_rst", 1, rsts)
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("ctrl_ovf", 32'h98, rd)
    wb(0, `ITW_IDX_STAT, 8'h00);
    `CHK("stat", 1'b1, rd[0])
    wb(1, `ITW_IDX_MASK, 8'h01);
    repeat (2) @(posedge mclk);
    `CHK("irq_on", 1'b1, irq)
    wb(1, `ITW_IDX_STAT, 8'h07);
    repeat (2) @(posedge mclk);
    `CHK("irq_off", 1'b0, irq)
    wb(1, `ITW_IDX_CTRL, 8'h00);
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("flag_wr", 32'h00, rd)
  endtask
  task automatic t_clear;
    wb(1, `ITW_IDX_CTRL, 8'h21);
    ticks(1500);
    wb(1, `ITW_IDX_CTRL, `ITW_CLR_CMD);
    ticks(1500);
    `CHK("clr_rst", 1, rsts)
    wb(1, `ITW_IDX_CTRL, 8'h01);
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("ctrl_locked", 32'h21, rd)
    ticks(548);
    `CHK("ovf2", 2, rsts)
    wb(1, `ITW_IDX_CTRL, 8'h00);
  endtask
  task automatic t_freeze;
    wb(1, `ITW_IDX_CTRL, 8'h30);
    ticks(1000);
    stby <= 1;
    ticks(100);
    stby <= 0;
    ticks(23);
    `CHK("frz_hold", 2, rsts)
    ticks(1);
    `CHK("frz_ovf", 3, rsts)
    wb(1, `ITW_IDX_CTRL, 8'h28);
    stby <= 1;
    repeat (3) @(posedge mclk);
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("sb_stop", 32'h08, rd)
    stby <= 0;
    rcs <= 1;
    repeat (3) @(posedge mclk);
    `CHK("rcs_req", 1'b1, rreq)
    rcs <= 0;
    repeat (3) @(posedge mclk);
    `CHK("rcs_off", 1'b0, rreq)
  endtask
  task automatic t_sub;
    wb(1, `ITW_IDX_CTRL, 8'h60);
    xen <= 0;
    repeat (4) @(posedge mclk);
    `CHK("sub_rst", 4, rsts)
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("sub_ctrl", 32'hc0, rd)
    wb(0, `ITW_IDX_STAT, 8'h00);
    `CHK("sub_stat", 32'h07, rd)
    xen <= 1;
    rcwdt_rst <= 1;
    @(posedge mclk);
    rcwdt_rst <= 0;
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("rcwdt", 32'h00, rd)
    wb(0, 16'h0123, 8'h00);
    `CHK("unmapped", 32'h00, rd)
    wb(1, `ITW_IDX_CTRL, 8'h60);
    hold <= 1;
    repeat (4) @(posedge mclk);
    `CHK("hold_rst", 5, rsts)
    hold <= 0;
  endtask
  task automatic wrap_up;
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 0;
    wb(0, `ITW_IDX_CTRL, 8'h00);
    `CHK("ctrl_rst", 32'h00, rd)
    t_overflow;
    t_clear;
    t_freeze;
    t_sub;
    wrap_up;
  end
endmodule
`default_nettype wire
